// [design/exec_defs.vh]
// register map, field layout, reset values and operation codes of the execute block
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// register byte offsets on the bus
`define OFS_INSTR      8'h00
`define OFS_WORKING    8'h04
`define OFS_PC         8'h08
`define OFS_PAGE       8'h0C
`define OFS_STATUS     8'h10
`define OFS_WATCHDOG   8'h14
`define OFS_FILE_ADDR  8'h18
`define OFS_FILE_DATA  8'h1C
`define OFS_STACK      8'h20

// instruction word layout
`define INSTR_W        11
`define INSTR_OP_HI    10
`define INSTR_OP_LO    8
`define INSTR_D_BIT    7
`define INSTR_F_HI     6

// operation codes
`define OP_NOP         3'h0
`define OP_WDT_CLEAR   3'h1
`define OP_CALL_W      3'h2
`define OP_COMPLEMENT  3'h3
`define OP_CLEAR_FILE  3'h4
`define OP_DECREMENT   3'h5
`define OP_CLEAR_W     3'h6
`define OP_DEC_SKIP    3'h7

// status register bit positions
`define ST_ZERO_BIT    0
`define ST_PD_BIT      3
`define ST_TO_BIT      4
`define ST_BUSY_BIT    8
`define ST_SKIP_BIT    9

// reset values
`define PC_RST         15'h0000
`define W_RST          8'h00
`define PAGE_RST       7'h00
`define INSTR_RST      11'h000

`endif

// [design/partial_instruction_execute.v]
// execute stage for the watchdog, call-via-working, complement, clear and decrement operations
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"

module partial_instruction_execute #(
	parameter FILE_DEPTH = 128,
	parameter STACK_AW   = 4,
	parameter PRE_W      = 8,
	parameter WDT_W      = 8
) (
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         wdt_clear_pulse,
	output reg         wdt_timeout_pulse,
	output reg         stack_push_pulse,
	output reg  [14:0] stack_push_addr
);

	// idle takes bus writes, exec runs one operation or a discarded slot, call2 loads the new pc
	localparam ST_IDLE  = 3'b001;
	localparam ST_EXEC  = 3'b010;
	localparam ST_CALL2 = 3'b100;

	// unit steps sized to each counter
	localparam [STACK_AW-1:0] SP_ONE  = {{(STACK_AW-1){1'b0}}, 1'b1};
	localparam [PRE_W-1:0]    PRE_ONE = {{(PRE_W-1){1'b0}}, 1'b1};
	localparam [WDT_W-1:0]    WDT_ONE = {{(WDT_W-1){1'b0}}, 1'b1};

	reg  [2:0]              state_r;
	reg  [`INSTR_W-1:0]     instr_r;
	reg  [7:0]              working_r;
	reg  [14:0]             pc_r;
	reg  [6:0]              pc_page_latch_r;
	reg                     zero_r;
	reg                     timeout_flag_n_r;
	reg                     powerdown_flag_n_r;
	reg                     skip_r;
	reg  [6:0]              file_addr_r;
	reg  [STACK_AW-1:0]     sp_r;
	reg  [PRE_W-1:0]        presc_r;
	reg  [WDT_W-1:0]        watchdog_counter_r;
	reg  [7:0]              file_mem [0:FILE_DEPTH-1];
	reg  [14:0]             stack_mem [0:(1<<STACK_AW)-1];
	reg  [31:0]             rdata;

	// result of the data operation on a file value
	function [7:0] alu_res;
		input [2:0] op;
		input [7:0] v;
		begin
			case (op)
				`OP_COMPLEMENT: alu_res = ~v;
				`OP_DECREMENT:  alu_res = v - 8'h01;
				`OP_DEC_SKIP:   alu_res = v - 8'h01;
				default:        alu_res = 8'h00;
			endcase
		end
	endfunction

	// true for addresses that hold a register
	function is_mapped;
		input [7:0] a;
		begin
			case (a)
				`OFS_INSTR, `OFS_WORKING, `OFS_PC, `OFS_PAGE, `OFS_STATUS,
				`OFS_WATCHDOG, `OFS_FILE_ADDR, `OFS_FILE_DATA, `OFS_STACK: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// true when an eight-bit result is zero
	function is_zero;
		input [7:0] v;
		begin
			is_zero = (v == 8'h00);
		end
	endfunction

	// instruction fields and decode
	wire [2:0]          op       = instr_r[`INSTR_OP_HI:`INSTR_OP_LO];
	wire                dsel     = instr_r[`INSTR_D_BIT];
	wire [6:0]          fa       = instr_r[`INSTR_F_HI:0];
	wire [7:0]          fval     = file_mem[fa];
	wire [7:0]          res      = alu_res(op, fval);
	wire                busy     = ~state_r[0];
	wire                executing = state_r[1] & ~skip_r;
	wire [14:0]         pc_inc   = pc_r + 15'h0001;
	wire [STACK_AW-1:0] sp_top   = sp_r - SP_ONE;
	wire                wr_go    = psel & penable & pready & pwrite & ~pslverr;
	wire                is_arith = (op == `OP_COMPLEMENT) | (op == `OP_DECREMENT) | (op == `OP_DEC_SKIP);
	wire                presc_wrap = &presc_r;

	// strobes of the operations that touch state outside the core registers
	wire                run_wdt_clear = executing & (op == `OP_WDT_CLEAR);
	wire                run_call      = executing & (op == `OP_CALL_W);
	wire                run_clear_f   = executing & (op == `OP_CLEAR_FILE);
	wire                res_zero      = is_zero(res);

	// register read mux
	always @* begin
		rdata = 32'h0000_0000;
		case (paddr)
			`OFS_INSTR:     rdata = {21'h000000, instr_r};
			`OFS_WORKING:   rdata = {24'h000000, working_r};
			`OFS_PC:        rdata = {17'h00000, pc_r};
			`OFS_PAGE:      rdata = {25'h0000000, pc_page_latch_r};
			`OFS_STATUS: begin
				rdata[`ST_ZERO_BIT] = zero_r;
				rdata[`ST_PD_BIT]   = powerdown_flag_n_r;
				rdata[`ST_TO_BIT]   = timeout_flag_n_r;
				rdata[`ST_BUSY_BIT] = busy;
				rdata[`ST_SKIP_BIT] = skip_r;
			end
			`OFS_WATCHDOG: begin
				rdata[WDT_W-1:0]  = watchdog_counter_r;
				rdata[8 +: PRE_W] = presc_r;
			end
			`OFS_FILE_ADDR: rdata = {25'h0000000, file_addr_r};
			`OFS_FILE_DATA: rdata = {24'h000000, file_mem[file_addr_r]};
			`OFS_STACK: begin
				rdata[14:0]           = stack_mem[sp_top];
				rdata[16 +: STACK_AW] = sp_r;
			end
			default:        rdata = 32'h0000_0000;
		endcase
	end

	// apb slave: access is held while an instruction is executing
	// ready and error stand one cycle, read data holds until the next access; a write lands where ready is seen high
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (pready) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && penable && !busy) begin
			pready  <= 1'b1;
			pslverr <= ~is_mapped(paddr);
			prdata  <= pwrite ? 32'h0000_0000 : rdata;
		end
	end

	// file register array: bus writes and operation results
	always @(posedge mclk) begin
		if (wr_go && paddr == `OFS_FILE_DATA)
			file_mem[file_addr_r] <= pwdata[7:0];
		else if (run_clear_f)
			file_mem[fa] <= 8'h00;
		else if (executing && is_arith && dsel)
			file_mem[fa] <= res;
	end

	// return stack array
	always @(posedge mclk) begin
		if (run_call)
			stack_mem[sp_r] <= pc_inc;
	end

	// watchdog prescaler and counter
	// a clear restarts the whole chain, so the next expiry is a full period away
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			presc_r            <= {PRE_W{1'b0}};
			watchdog_counter_r <= {WDT_W{1'b0}};
			wdt_timeout_pulse  <= 1'b0;
		end else begin
			wdt_timeout_pulse <= 1'b0;
			if (run_wdt_clear) begin
				presc_r            <= {PRE_W{1'b0}};
				watchdog_counter_r <= {WDT_W{1'b0}};
			end else begin
				presc_r <= presc_r + PRE_ONE;
				if (presc_wrap) begin
					watchdog_counter_r <= watchdog_counter_r + WDT_ONE;
					if (&watchdog_counter_r)
						wdt_timeout_pulse <= 1'b1;
				end
			end
		end
	end

	// sequencer and architectural state
	// a pending skip turns the next issued word into a no-operation that only steps pc
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r            <= ST_IDLE;
			instr_r            <= `INSTR_RST;
			working_r          <= `W_RST;
			pc_r               <= `PC_RST;
			pc_page_latch_r    <= `PAGE_RST;
			zero_r             <= 1'b0;
			timeout_flag_n_r   <= 1'b1;
			powerdown_flag_n_r <= 1'b1;
			skip_r             <= 1'b0;
			file_addr_r        <= 7'h00;
			sp_r               <= {STACK_AW{1'b0}};
			wdt_clear_pulse    <= 1'b0;
			stack_push_pulse   <= 1'b0;
			stack_push_addr    <= 15'h0000;
		end else begin
			wdt_clear_pulse  <= 1'b0;
			stack_push_pulse <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (wr_go) begin
						case (paddr)
							`OFS_INSTR: begin
								instr_r <= pwdata[`INSTR_W-1:0];
								state_r <= ST_EXEC;
							end
							`OFS_WORKING:   working_r <= pwdata[7:0];
							`OFS_PC:        pc_r <= pwdata[14:0];
							`OFS_PAGE:      pc_page_latch_r <= pwdata[6:0];
							`OFS_FILE_ADDR: file_addr_r <= pwdata[6:0];
							`OFS_STATUS: begin
								zero_r             <= pwdata[`ST_ZERO_BIT];
								powerdown_flag_n_r <= pwdata[`ST_PD_BIT];
								timeout_flag_n_r   <= pwdata[`ST_TO_BIT];
							end
							default: ;
						endcase
					end
				end
				ST_EXEC: begin
					state_r <= ST_IDLE;
					pc_r    <= pc_inc;
					if (skip_r) begin
						skip_r <= 1'b0;                // fetched word runs as a no-operation
					end else begin
						case (op)
							`OP_WDT_CLEAR: begin
								timeout_flag_n_r   <= 1'b1;
								powerdown_flag_n_r <= 1'b1;
								wdt_clear_pulse    <= 1'b1;
							end
							`OP_CALL_W: begin
								sp_r             <= sp_r + SP_ONE;
								stack_push_pulse <= 1'b1;
								stack_push_addr  <= pc_inc;
								pc_r             <= pc_r;
								state_r          <= ST_CALL2;
							end
							`OP_COMPLEMENT, `OP_DECREMENT: begin
								if (!dsel)
									working_r <= res;
								zero_r <= res_zero;
							end
							`OP_CLEAR_FILE: zero_r <= 1'b1;
							`OP_CLEAR_W: begin
								working_r <= 8'h00;
								zero_r    <= 1'b1;
							end
							`OP_DEC_SKIP: begin
								if (!dsel)
									working_r <= res;        // zero flag untouched
								skip_r <= res_zero;
							end
							default: ;
						endcase
					end
				end
				ST_CALL2: begin
					pc_r    <= {pc_page_latch_r, working_r};
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
			// expiry drops the timeout flag last, so it wins over a watchdog clear
			// or a status write in the same cycle; a counter wrap in the cycle of a clear raises no timeout pulse
			if (wdt_timeout_pulse)
				timeout_flag_n_r <= 1'b0;
		end
	end

endmodule // partial_instruction_execute

`default_nettype wire

// [sim/exec_chk.sv]
// port-level checker for the execute block
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"
module exec_chk (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        wdt_clear_pulse,
	input wire logic        wdt_timeout_pulse,
	input wire logic        stack_push_pulse,
	input wire logic [14:0] stack_push_addr
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [2:0] clr_sh_r;
	logic [2:0] call_sh_r;
	logic       issue;
	// recent issues of the watchdog clear and call operations
	assign issue = pready && pwrite && paddr == `OFS_INSTR;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			clr_sh_r <= 3'h0;
			call_sh_r <= 3'h0;
		end else begin
			clr_sh_r <= {clr_sh_r[1:0], issue && pwdata[10:8] == `OP_WDT_CLEAR};
			call_sh_r <= {call_sh_r[1:0], issue && pwdata[10:8] == `OP_CALL_W};
		end
	end
	sequence s_acc; psel && penable; endsequence
	sequence s_drop; !pready; endsequence
	property p_rdy; pready |-> s_acc ##1 s_drop; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_wzero; pready && pwrite |-> prdata == 32'h0; endproperty
	property p_clr_cause; wdt_clear_pulse |-> |clr_sh_r; endproperty
	property p_clr_pulse; wdt_clear_pulse |=> !wdt_clear_pulse; endproperty
	property p_push_cause; stack_push_pulse |-> |call_sh_r; endproperty
	property p_push_hold; $changed(stack_push_addr) |-> stack_push_pulse; endproperty
	property p_tmo_pulse; wdt_timeout_pulse |=> !wdt_timeout_pulse; endproperty
	a_rdy: assert property (p_rdy) else $error("ready without access");
	a_err: assert property (p_err) else $error("error without ready");
	a_wzero: assert property (p_wzero) else $error("read data on write");
	a_clr_cause: assert property (p_clr_cause) else $error("stray clear pulse");
	a_clr_pulse: assert property (p_clr_pulse) else $error("long clear pulse");
	a_push_cause: assert property (p_push_cause) else $error("stray push");
	a_push_hold: assert property (p_push_hold) else $error("push address moved");
	a_tmo_pulse: assert property (p_tmo_pulse) else $error("long timeout pulse");
endmodule // exec_chk
bind partial_instruction_execute exec_chk u_chk (.*);
`default_nettype wire

// [sim/partial_instruction_execute_tb_top.sv]
// self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"
module partial_instruction_execute_tb_top;
	logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00, w, f, fv, r;
	logic [31:0] pwdata = 32'h0, prdata, seed = 15466, t;
	logic        pready, pslverr, tmo, z = 0, sk = 0, d, cw, clr_p, push_p;
	logic [6:0]  fa, pg;
	logic [14:0] pc = 15'h0, ret, push_a;
	logic [2:0]  op;
	logic [64:0] q[$], e;
	logic [15:0] ev[$], ee;
	int          n_errors = 0, n_compared = 0;
	partial_instruction_execute #(.PRE_W(2)) uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wdt_clear_pulse(clr_p), .wdt_timeout_pulse(tmo),
		.stack_push_pulse(push_p), .stack_push_addr(push_a));
	always #5 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// one apb transfer, held until ready is sampled
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] dd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dd;
		@(posedge mclk) penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic er);
		q.push_back({er, m, x});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic chk(input logic [64:0] x);
		n_compared++;
		if ({pslverr, prdata & x[63:32]} !== {x[64], x[31:0]}) begin
			n_errors++;
			$display("unexpected at %0t: read %h exp %h", $time, prdata, x[31:0]);
		end
	endtask
	// event note: {clear pulse, pushed address}
	task automatic chk_ev(input logic [15:0] x);
		n_compared++;
		if ({clr_p, push_p ? push_a : 15'h0} !== x) begin
			n_errors++;
			$display("unexpected at %0t: event %h exp %h", $time, {clr_p, push_a}, x);
		end
	endtask
	task automatic results();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// read results are matched against the oldest note
	always @(posedge mclk) begin
		if (pready === 1'b1 && pwrite === 1'b0 && q.size() > 0) begin
			e = q.pop_front();
			chk(e);
		end
		if (clr_p === 1'b1 || push_p === 1'b1) begin
			ee = ev.size() > 0 ? ev.pop_front() : 16'hFFFF;
			chk_ev(ee);
		end
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		results();
	end
	// main sequence: operations in falling order three times, so each skip lands on a clear of working
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 24; i++) begin
			t = rnd();
			op = 3'h7 - i[2:0];
			fa = t[6:0];
			d = t[7];
			fv = i < 8 ? 8'h01 : t[15:8];
			w = t[23:16];
			pg = t[30:24];
			xfer(1'b1, `OFS_FILE_ADDR, {25'h0, fa});
			xfer(1'b1, `OFS_FILE_DATA, {24'h0, fv});
			xfer(1'b1, `OFS_WORKING, {24'h0, w});
			xfer(1'b1, `OFS_PAGE, {25'h0, pg});
			xfer(1'b1, `OFS_INSTR, {21'h0, op, d, fa});
			f = fv;
			cw = 1'b0;
			if (sk) begin
				sk = 1'b0;
				op = 3'h0;
			end
			r = op == 3'h3 ? ~fv : fv - 8'h01;
			ret = pc + 15'h1;
			case (op)
				3'h1: ev.push_back(16'h8000);
				3'h2: begin
					cw = 1'b1;
					ev.push_back({1'b0, ret});
				end
				3'h3, 3'h5, 3'h7: begin
					f = d ? r : f;
					w = d ? w : r;
					z = op == 3'h7 ? z : r == 8'h00;
					sk = op == 3'h7 && r == 8'h00;
				end
				3'h4: {f, z} = 9'h001;
				3'h6: {w, z} = 9'h001;
				default: ;
			endcase
			pc = cw ? {pg, w} : ret;
			rd(`OFS_WORKING, 32'hFF, {24'h0, w}, 1'b0);
			rd(`OFS_FILE_DATA, 32'hFF, {24'h0, f}, 1'b0);
			rd(`OFS_PC, 32'h7FFF, {17'h0, pc}, 1'b0);
			rd(`OFS_STATUS, 32'h201, {22'h0, sk, 8'h0, z}, 1'b0);
			if (cw)
				rd(`OFS_STACK, 32'h7FFF, {17'h0, ret}, 1'b0);
		end
		$display("operation test done");
		xfer(1'b1, `OFS_INSTR, 32'h0);
		for (int k = 0; k < 1200 && tmo !== 1'b1; k++) @(posedge mclk);
		@(posedge mclk);
		rd(`OFS_STATUS, 32'h10, 32'h0, 1'b0); // expiry drops timeout_flag_n
		// drop powerdown_flag_n too and let the counter climb well away from zero
		xfer(1'b1, `OFS_STATUS, {31'h0, z});
		repeat (300) @(posedge mclk);
		ev.push_back(16'h8000);
		xfer(1'b1, `OFS_INSTR, 32'h100);
		rd(`OFS_WATCHDOG, 32'hFF, 32'h0, 1'b0);
		rd(`OFS_STATUS, 32'h19, {27'h0, 2'b11, 2'b00, z}, 1'b0);
		$display("watchdog test done");
		rd(8'hFC, 32'hFFFFFFFF, 32'h0, 1'b1);
		$display("bus error test done");
		if (q.size() != 0 || ev.size() != 0) begin
			n_errors++;
			$display("unexpected at %0t: %0d notes never matched", $time, q.size() + ev.size());
		end
		results();
	end
endmodule // partial_instruction_execute_tb_top
`default_nettype wire
